//--- inc/fifo_host_pkg.sv
// Constants, states and pin bundles for the elastic FIFO host controller.
package fifo_host_pkg;

  // ------------------------------------------------------------------
  // Geometry of the external store
  // ------------------------------------------------------------------
  localparam int WORD_W = 4;
  localparam int DEPTH = 16;
  localparam int FILL_W = 5;
  localparam logic [FILL_W-1:0] FILL_FULL = 5'h10;
  localparam logic [FILL_W-1:0] FILL_RST = 5'h00;

  // ------------------------------------------------------------------
  // Timing, each time in ns and its cycle count at the clock rate
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLEAR_PULSE_NS = 100;
  localparam int PUSH_HIGH_NS = 40;
  localparam int PUSH_LOW_NS = 40;
  localparam int TMR_W = 4;
  localparam logic [TMR_W-1:0] CLEAR_CYCLES =
    TMR_W'((CLEAR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PUSH_HIGH_CYCLES =
    TMR_W'((PUSH_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] PUSH_LOW_CYCLES =
    TMR_W'((PUSH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_RST = 4'h0;

  // ------------------------------------------------------------------
  // State machines
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {W_CLEAR, W_IDLE, W_HIGH, W_LOW} wr_state_t;
  typedef enum logic [1:0] {R_IDLE, R_RAISE, R_FALL, R_SETTLE} rd_state_t;

  // ------------------------------------------------------------------
  // Pin bundles facing the FIFO device
  // ------------------------------------------------------------------
  typedef struct packed {
    logic clear_all;
    logic push_strobe;
    logic pop_strobe;
    logic read_oe_n;
    logic [WORD_W-1:0] write_word;
  } fifo_drive_t;

  typedef struct packed {
    logic input_space;
    logic output_valid_flag;
    logic [WORD_W-1:0] read_word;
  } fifo_sense_t;

  localparam fifo_drive_t DRIVE_RST = '{clear_all: 1'b1, push_strobe: 1'b0,
    pop_strobe: 1'b0, read_oe_n: 1'b1, write_word: 4'h0};

endpackage

//--- rtl/fifo_host_ctrl.sv
// Host controller that drives an elastic 16x4 FIFO device through its pins.
`timescale 1ns/1ps
`default_nettype none

module fifo_host_ctrl
  import fifo_host_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_req_i,
  input wire logic [WORD_W-1:0] wr_data_i,
  input wire logic rd_req_i,
  input wire fifo_sense_t dev_i,
  output logic wr_ack_o,
  output logic rd_valid_o,
  output logic [WORD_W-1:0] rd_word_o,
  output logic ready_o,
  output fifo_drive_t dev_o
);

  // A push may start only when the device shows space and our count agrees.
  // no push while full
  function automatic logic push_ok(input logic space, input logic [FILL_W-1:0] fill);
    push_ok = space && (fill < FILL_FULL);
  endfunction

  wr_state_t wr_st_q, wr_st_d;
  rd_state_t rd_st_q, rd_st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [FILL_W-1:0] fill_q, fill_d;
  fifo_drive_t drv_q, drv_d;
  logic wr_ack_q, wr_ack_d;
  logic rd_valid_q, rd_valid_d;
  logic [WORD_W-1:0] rd_word_q, rd_word_d;
  logic ready_q, ready_d;
  logic push_rise, pop_fall;

  // ------------------------------------------------------------------
  // Write side: clear after reset, then push strobes
  // ------------------------------------------------------------------

  // Next write state, strobe timing and clear pulse.
  always_comb
  begin
    wr_st_d = wr_st_q;
    tmr_d = tmr_q;
    wr_ack_d = 1'b0;
    drv_d = drv_q;
    push_rise = 1'b0;
    unique case (wr_st_q)
      W_CLEAR:
      begin
        if (tmr_q >= CLEAR_CYCLES - 4'h1)
        begin
          drv_d.clear_all = 1'b0;
          wr_st_d = W_IDLE;
          tmr_d = TMR_RST;
        end
        else
        begin
          tmr_d = tmr_q + 4'h1;
        end
      end
      W_IDLE:
      begin
        if (wr_req_i && push_ok(dev_i.input_space, fill_q))
        begin
          drv_d.write_word = wr_data_i;
          drv_d.push_strobe = 1'b1;
          push_rise = 1'b1;
          wr_ack_d = 1'b1;
          wr_st_d = W_HIGH;
          tmr_d = TMR_RST;
        end
      end
      W_HIGH:
      begin
        if (tmr_q >= PUSH_HIGH_CYCLES - 4'h1)
        begin
          drv_d.push_strobe = 1'b0;
          wr_st_d = W_LOW;
          tmr_d = TMR_RST;
        end
        else
        begin
          tmr_d = tmr_q + 4'h1;
        end
      end
      W_LOW:
      begin
        // The low time lets the device finish the push before the next one.
        if (tmr_q >= PUSH_LOW_CYCLES - 4'h1)
        begin
          wr_st_d = W_IDLE;
          tmr_d = TMR_RST;
        end
        else
        begin
          tmr_d = tmr_q + 4'h1;
        end
      end
    endcase
    drv_d.pop_strobe = (rd_st_d == R_RAISE);
    drv_d.read_oe_n = !((rd_st_d == R_RAISE) || (rd_st_d == R_FALL));
  end

  // ------------------------------------------------------------------
  // Read side: pop strobe with output enable around the sample
  // ------------------------------------------------------------------

  // Next read state; the word is sampled before the strobe falls.
  always_comb
  begin
    rd_st_d = rd_st_q;
    rd_valid_d = 1'b0;
    rd_word_d = rd_word_q;
    pop_fall = 1'b0;
    unique case (rd_st_q)
      R_IDLE:
      begin
        if (rd_req_i && dev_i.output_valid_flag && (wr_st_q != W_CLEAR))
        begin
          rd_st_d = R_RAISE;
        end
      end
      R_RAISE:
      begin
        // Outputs have been enabled for a full cycle, so the word is settled.
        rd_word_d = dev_i.read_word;
        rd_valid_d = 1'b1;
        rd_st_d = R_FALL;
      end
      R_FALL:
      begin
        pop_fall = 1'b1;
        rd_st_d = R_SETTLE;
      end
      R_SETTLE:
      begin
        // A stale flag would start a second pop of a word already taken.
        if (!dev_i.output_valid_flag)
        begin
          rd_st_d = R_IDLE;
        end
      end
    endcase
  end

  // Occupancy count kept by the host, since burst use ignores the flags.
  // Readiness lives here so no process reads back a value it feeds.
  always_comb
  begin
    fill_d = fill_q;
    ready_d = 1'b0;
    if (push_rise && !pop_fall)
    begin
      fill_d = fill_q + 5'h01;
    end
    else if (pop_fall && !push_rise && (fill_q != FILL_RST))
    begin
      fill_d = fill_q - 5'h01;
    end
    // Readiness looks one cycle ahead so the output comes from a flop.
    ready_d = (wr_st_d == W_IDLE) && (fill_d < FILL_FULL);
  end

  // Register all state; synchronous reset restarts the clear pulse.
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_st_q <= W_CLEAR;
      rd_st_q <= R_IDLE;
      tmr_q <= TMR_RST;
      fill_q <= FILL_RST;
      drv_q <= DRIVE_RST;
      wr_ack_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_word_q <= 4'h0;
      ready_q <= 1'b0;
    end
    else
    begin
      wr_st_q <= wr_st_d;
      rd_st_q <= rd_st_d;
      tmr_q <= tmr_d;
      fill_q <= fill_d;
      drv_q <= drv_d;
      wr_ack_q <= wr_ack_d;
      rd_valid_q <= rd_valid_d;
      rd_word_q <= rd_word_d;
      ready_q <= ready_d;
    end
  end

  assign dev_o = drv_q;
  assign wr_ack_o = wr_ack_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_word_o = rd_word_q;
  assign ready_o = ready_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------

  property p_clear_pulse;
    @(posedge clk_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> drv_q.clear_all [*5] ##1 !drv_q.clear_all;
  endproperty
  a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse wrong length");

  property p_push_on_space;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(drv_q.push_strobe) |-> $past(dev_i.input_space) && !drv_q.clear_all;
  endproperty
  a_push_on_space: assert property (p_push_on_space) else $error("push without space");

  property p_push_shape;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(drv_q.push_strobe) |-> drv_q.push_strobe [*2] ##1 !drv_q.push_strobe [*2];
  endproperty
  a_push_shape: assert property (p_push_shape) else $error("push strobe shape wrong");

  property p_capacity;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(drv_q.push_strobe) |-> $past(fill_q) < FILL_FULL && fill_q <= FILL_FULL;
  endproperty
  a_capacity: assert property (p_capacity) else $error("push beyond capacity");

  property p_full_no_push;
    @(posedge clk_i) disable iff (sys_rst_i)
      (fill_q == FILL_FULL) |=> !$rose(drv_q.push_strobe);
  endproperty
  a_full_no_push: assert property (p_full_no_push) else $error("push while full");

  property p_pop_falls;
    @(posedge clk_i) disable iff (sys_rst_i)
      $rose(drv_q.pop_strobe) |-> !drv_q.read_oe_n ##1 !drv_q.pop_strobe && rd_valid_o;
  endproperty
  a_pop_falls: assert property (p_pop_falls) else $error("pop strobe held too long");

  c_push: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(drv_q.push_strobe));
  c_pop: cover property (@(posedge clk_i) disable iff (sys_rst_i) rd_valid_o);
  c_full: cover property (@(posedge clk_i) disable iff (sys_rst_i) fill_q == FILL_FULL);
  c_both: cover property (@(posedge clk_i) disable iff (sys_rst_i) push_rise && pop_fall);

endmodule

`default_nettype wire

//--- test/fifo_dev_model.sv
// Behavioural model of the elastic 16x4 FIFO device.
`timescale 1ns/1ps
`default_nettype none

module fifo_dev_model
  import fifo_host_pkg::*;
#(
  parameter int RIPPLE_CYCLES = 3
)
(
  input wire logic clk_i,
  input wire fifo_drive_t drive_i,
  output fifo_sense_t sense_o
);
  // ----------------------------------------------------------------
  // Store, output stage and flags
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] store_q[$];
  logic [WORD_W-1:0] out_q = 4'hA; // Power-up content is arbitrary.
  logic have = 1'b0;
  logic valid_q = 1'b0;
  logic busy_q = 1'b0;
  logic push_q = 1'b0;
  logic pop_q = 1'b0;
  logic clr_q = 1'b0;
  int fill_q = 0;
  int wait_c = 0;

  // read pins, space returns
  // Released pins show the inverse, so stale data never passes.
  assign sense_o = '{input_space: !busy_q && (fill_q < DEPTH),
    output_valid_flag: valid_q,
    read_word: drive_i.read_oe_n ? ~out_q : out_q};

  // Strobe edges are seen on the host clock; the real part reacts to raw edges.
  always @(posedge clk_i)
  begin
    push_q <= drive_i.push_strobe;
    pop_q <= drive_i.pop_strobe;
    clr_q <= drive_i.clear_all;
    if (drive_i.clear_all)
    begin
      store_q.delete();
      have = 1'b0;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      if (drive_i.push_strobe && (!push_q || clr_q))
      begin
        store_q.push_back(drive_i.write_word);
        busy_q <= 1'b1;
      end
      if (!drive_i.push_strobe && push_q)
        busy_q <= 1'b0;
      if (!drive_i.pop_strobe && pop_q && have)
      begin
        have = 1'b0;
        valid_q <= 1'b0;
        wait_c = RIPPLE_CYCLES;
      end
      else if (!have && store_q.size() > 0)
      begin
        if (wait_c > 0)
          wait_c--;
        else
        begin
          out_q <= store_q.pop_front();
          have = 1'b1;
          valid_q <= 1'b1;
        end
      end
    end
    fill_q <= store_q.size() + int'(have);
  end
endmodule

`default_nettype wire

//--- test/test_fifo_host_ctrl.sv
// Self-checking bench for the elastic FIFO host controller.
`timescale 1ns/1ps
`default_nettype none

module test_fifo_host_ctrl
  import fifo_host_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus, model and scoreboard
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_req_i = 1'b0;
  logic [WORD_W-1:0] wr_data_i = 4'h0;
  logic rd_req_i = 1'b0;
  fifo_sense_t dev_i;
  fifo_drive_t dev_o;
  logic wr_ack_o;
  logic rd_valid_o;
  logic [WORD_W-1:0] rd_word_o;
  logic ready_o;
  logic [WORD_W-1:0] expect_q[$];
  logic [WORD_W-1:0] last_word = 4'h0;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  fifo_host_ctrl fifo_host_ctrl_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wr_req_i(wr_req_i), .wr_data_i(wr_data_i), .rd_req_i(rd_req_i), .dev_i(dev_i),
    .wr_ack_o(wr_ack_o), .rd_valid_o(rd_valid_o), .rd_word_o(rd_word_o),
    .ready_o(ready_o), .dev_o(dev_o));
  fifo_dev_model fifo_dev_model_inst (.clk_i(clk_i), .drive_i(dev_o), .sense_o(dev_i));

  // Free-running 50 MHz clock.
  always #10 clk_i = ~clk_i;

  // A hung handshake must not stall the run, so a ceiling forces the report.
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [WORD_W-1:0] bit4(input logic b);
    return {3'h0, b};
  endfunction

  // Host is ready only while its count is below capacity.
  function automatic logic [WORD_W-1:0] exp_space(input int fill);
    return bit4(fill < DEPTH);
  endfunction

  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] want);
    comparisons++;
    if (got !== want)
    begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask

  task automatic push(input logic [WORD_W-1:0] w, input logic taken);
    int n;
    n = 0;
    wr_req_i = 1'b1;
    wr_data_i = w;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (wr_ack_o !== 1'b1 && n < 100);
    wr_req_i = 1'b0;
    if (n < 100)
    begin
      expect_q.push_back(w);
      check(dev_o.write_word, w);
      check(bit4(dev_o.push_strobe), 4'h1);
    end
    check(bit4(n < 100), bit4(taken));
  endtask

  task automatic pop(input logic taken);
    int n;
    n = 0;
    rd_req_i = 1'b1;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (rd_valid_o !== 1'b1 && n < 100);
    rd_req_i = 1'b0;
    if (n < 100)
    begin
      check(bit4(dev_o.read_oe_n), 4'h0);
      check(bit4(dev_o.pop_strobe), 4'h0);
      last_word = expect_q.pop_front();
    end
    check(rd_word_o, last_word);
    check(bit4(n < 100), bit4(taken));
  endtask

  task automatic reset_host(input int len);
    int n;
    n = 0;
    sys_rst_i = 1'b1;
    repeat (len) @(negedge clk_i);
    check(bit4(dev_o.clear_all), 4'h1);
    check(bit4(ready_o), 4'h0);
    sys_rst_i = 1'b0;
    while (ready_o !== 1'b1 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    check(bit4(dev_o.clear_all), 4'h0);
    check(bit4(ready_o), exp_space(0));
  endtask

  // Corner cases first, then a random producer and consumer, then a clear.
  initial
  begin
    void'($urandom(94280));
    reset_host(10);
    check(bit4(dev_o.read_oe_n), 4'h1);
    for (int n = 0; n < DEPTH; n++)
      push(n == 0 ? 4'hF : 4'($urandom()), 1'b1);
    // The last push must finish before both flags reflect a full store.
    repeat (6) @(negedge clk_i);
    check(bit4(ready_o), exp_space(DEPTH));
    check(bit4(dev_i.input_space), 4'h0);
    push(4'h3, 1'b0);
    pop(1'b1);
    push(4'h0, 1'b1);
    for (int n = 0; n < DEPTH; n++)
      pop(1'b1);
    pop(1'b0);
    fork
      for (int i = 0; i < 40; i++)
      begin
        push(4'($urandom()), 1'b1);
        repeat ($urandom_range(6)) @(negedge clk_i);
      end
      for (int i = 0; i < 40; i++)
      begin
        pop(1'b1);
        repeat ($urandom_range(6)) @(negedge clk_i);
      end
    join
    push(4'h5, 1'b1);
    push(4'hA, 1'b1);
    reset_host(3);
    expect_q.delete();
    last_word = 4'h0;
    pop(1'b0);
    push(4'h9, 1'b1);
    pop(1'b1);
    end_sim();
  end
endmodule

`default_nettype wire
